// ===== rtl/tcdma_ctrl.sv
// Two channel transfer controller: registers, one shared sequencer, arbitration.
// Assumes an APB master and an outside bus unit that runs each cycle
// requested on cyc_req and pulses cyc_done when it ends.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module tcdma_ctrl
   import tcdma_pkg::*;
(
   input  wire logic        clk,         // 100 MHz clock
   input  wire logic        rst,         // Synchronous reset, high
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB write
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error
   input  wire logic [1:0]  xfer_req,    // External requests per channel
   input  wire logic        timer_req,   // Timer 2 request
   input  wire logic        nmi_req,     // Non-maskable interrupt
   input  wire logic        cyc_done,    // Bus cycle finished
   output logic             cyc_req,     // Bus cycle request
   output logic             cyc_store,   // 1 store, 0 fetch
   output logic      [19:0] cyc_addr,    // Bus cycle address
   output logic             cyc_mem,     // 1 memory, 0 I/O space
   output logic             cyc_word,    // 1 word, 0 byte
   output logic             cyc_chan,    // Channel owning the cycle
   output logic      [1:0]  irq          // Termination interrupt pulses
);
   logic [15:0] ctl_r [2];
   logic [19:0] src_r [2];
   logic [19:0] dst_r [2];
   logic [15:0] cnt_r [2];
   logic [1:0]  rq_s1_r;
   logic [1:0]  rq_s2_r;
   logic [1:0]  lastch_r;
   tcdma_st_e   st_r;
   logic        ch_r;
   logic [1:0]  gap_r;
   logic [1:0]  want;
   logic        pick;
   logic        acc;
   logic        wr;
   logic [4:0]  roff;
   logic        rch;
   logic        done_fetch;
   logic        done_store;

   assign acc  = psel && penable;
   assign wr   = acc && pwrite;
   assign roff = paddr[4:0];
   assign rch  = paddr[5];

   function automatic logic [19:0] step(input logic [19:0] p,
                                        input logic inc,
                                        input logic dec,
                                        input logic word);
      logic [19:0] d;
      d = word ? 20'h00002 : 20'h00001;
      if (inc && !dec)
         step = p + d;
      else if (dec && !inc)
         step = p - d;
      else
         step = p;
   endfunction : step

   function automatic logic req_ok(input logic [15:0] c, input logic x,
                                   input logic t);
      logic r;
      r = x || (t && c[B_TIMER]);
      unique case (tcdma_syn_e'(c[B_SYNL+1:B_SYNL]))
         SYN_NONE: req_ok = 1'b1;
         SYN_SRC:  req_ok = r;
         SYN_DST:  req_ok = r;
         SYN_UNUS: req_ok = 1'b0;
      endcase
   endfunction : req_ok

   // A count of one means this transfer is the last before zero
   function automatic logic last_xfer(input logic [15:0] n);
      last_xfer = n == 16'h0001;
   endfunction : last_xfer

   // Request synchronizer; only stage two feeds the sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         rq_s1_r <= 2'b00;
         rq_s2_r <= 2'b00;
      end else begin
         rq_s1_r <= xfer_req;
         rq_s2_r <= rq_s1_r;
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++)
         want[i] = ctl_r[i][B_RUN] && !nmi_req
                   && req_ok(ctl_r[i], rq_s2_r[i], timer_req);
   end

   // Higher priority wins; equal priority alternates
   always_comb begin
      if (want == 2'b11) begin
         if (ctl_r[0][B_PRIO] != ctl_r[1][B_PRIO])
            pick = ctl_r[1][B_PRIO];
         else
            pick = !lastch_r[0];
      end else begin
         pick = want[1];
      end
   end

   assign done_fetch = (st_r == ST_FETCH) && cyc_done;
   assign done_store = (st_r == ST_STORE) && cyc_done;

   // Sequencer; NMI only blocks new starts from idle, bus unit owns the cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r     <= ST_IDLE;
         ch_r     <= 1'b0;
         gap_r    <= 2'b00;
         lastch_r <= 2'b00;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               if (|want) begin
                  st_r     <= ST_FETCH;
                  ch_r     <= pick;
                  lastch_r <= {1'b0, pick};
               end
            end
            ST_FETCH: begin
               if (cyc_done)
                  st_r <= ST_STORE;
            end
            ST_STORE: begin
               if (cyc_done) begin
                  if (ctl_r[ch_r][B_SYNL+1:B_SYNL] == SYN_DST) begin
                     st_r  <= ST_GAP;
                     gap_r <= 2'(TCDMA_GAP_CYC - 1);
                  end else begin
                     st_r <= ST_IDLE;
                  end
               end
            end
            ST_GAP: begin
               if (gap_r == 2'b00)
                  st_r <= ST_IDLE;
               else
                  gap_r <= gap_r - 2'b01;
            end
         endcase
         if (nmi_req && st_r == ST_IDLE)
            st_r <= ST_IDLE;
      end
   end

   // Bus cycle outputs come from flops; no acknowledge pin exists
   always_ff @(posedge clk) begin
      if (rst) begin
         cyc_req   <= 1'b0;
         cyc_store <= 1'b0;
         cyc_addr  <= 20'h00000;
         cyc_mem   <= 1'b0;
         cyc_word  <= 1'b0;
         cyc_chan  <= 1'b0;
      end else begin
         cyc_req   <= 1'b0;
         if (st_r == ST_IDLE && |want) begin
            cyc_req   <= 1'b1;
            cyc_store <= 1'b0;
            cyc_addr  <= src_r[pick];
            cyc_mem   <= ctl_r[pick][B_SMEM];
            cyc_word  <= ctl_r[pick][B_WORD];
            cyc_chan  <= pick;
         end else if (done_fetch) begin
            cyc_req   <= 1'b1;
            cyc_store <= 1'b1;
            cyc_addr  <= dst_r[ch_r];
            cyc_mem   <= ctl_r[ch_r][B_DMEM];
            cyc_word  <= ctl_r[ch_r][B_WORD];
         end
      end
   end

   // Per-channel registers and end-of-transfer updates
   for (genvar g = 0; g < 2; g++) begin : g_ch
      logic sel;
      logic fin;
      logic zero;
      logic stop_now;
      // Unmapped upper addresses must not alias onto a channel
      assign sel  = wr && rch == 1'(g) && paddr[7:6] == 2'b00;
      assign fin  = done_store && ch_r == 1'(g);
      assign zero = last_xfer(cnt_r[g]);
      // Zero count clears run in every mode; count-stop adds nothing
      assign stop_now = fin && zero;

      always_ff @(posedge clk) begin
         if (rst) begin
            ctl_r[g] <= TCDMA_CTRL_RST;
         end else begin
            if (sel && roff == TCDMA_CTRL[4:0]) begin
               ctl_r[g][15:2] <= pwdata[15:2];
               ctl_r[g][B_RUNWE] <= 1'b0;
               ctl_r[g][3] <= 1'b0;
               ctl_r[g][B_WORD] <= pwdata[B_WORD];
               if (pwdata[B_RUNWE])
                  ctl_r[g][B_RUN] <= pwdata[B_RUN];
            end
            if (stop_now && (ctl_r[g][B_TCSTP]
                || ctl_r[g][B_SYNL+1:B_SYNL] == SYN_NONE))
               ctl_r[g][B_RUN] <= 1'b0;
            else if (stop_now)
               ctl_r[g][B_RUN] <= 1'b0;
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            src_r[g] <= 20'h00000;
            dst_r[g] <= 20'h00000;
            cnt_r[g] <= 16'h0000;
         end else begin
            if (fin) begin
               src_r[g] <= step(src_r[g], ctl_r[g][B_SINC],
                                ctl_r[g][B_SDEC], ctl_r[g][B_WORD]);
               dst_r[g] <= step(dst_r[g], ctl_r[g][B_DINC],
                                ctl_r[g][B_DDEC], ctl_r[g][B_WORD]);
               cnt_r[g] <= cnt_r[g] - 16'h0001;
            end
            if (sel && roff == TCDMA_SRC_LO[4:0])
               src_r[g][15:0] <= pwdata[15:0];
            if (sel && roff == TCDMA_SRC_HI[4:0])
               src_r[g][19:16] <= pwdata[3:0];
            if (sel && roff == TCDMA_DST_LO[4:0])
               dst_r[g][15:0] <= pwdata[15:0];
            if (sel && roff == TCDMA_DST_HI[4:0])
               dst_r[g][19:16] <= pwdata[3:0];
            if (sel && roff == TCDMA_CNT[4:0])
               cnt_r[g] <= pwdata[15:0];
         end
      end

   end

   // One process owns both pulse bits so each has a single driver
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++)
            irq[i] <= done_store && ch_r == 1'(i) && last_xfer(cnt_r[i])
                      && ctl_r[i][B_INTEN];
      end
   end

   // APB answers in the access cycle; reads registered for pready
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            pslverr <= paddr[7:6] != 2'b00 || paddr[1:0] != 2'b00
                       || roff > TCDMA_STAT[4:0];
            if (!pwrite) begin
               unique case (roff)
                  TCDMA_SRC_LO[4:0]: prdata <= {16'h0000, src_r[rch][15:0]};
                  TCDMA_SRC_HI[4:0]: prdata <= 32'(src_r[rch][19:16]);
                  TCDMA_DST_LO[4:0]: prdata <= {16'h0000, dst_r[rch][15:0]};
                  TCDMA_DST_HI[4:0]: prdata <= 32'(dst_r[rch][19:16]);
                  TCDMA_CNT[4:0]:    prdata <= {16'h0000, cnt_r[rch]};
                  TCDMA_CTRL[4:0]:   prdata <= {16'h0000, ctl_r[rch]};
                  TCDMA_STAT[4:0]:   prdata <= {28'h0000000, st_r,
                                                ch_r, 1'b0};
                  default:           prdata <= 32'h00000000;
               endcase
            end
         end
      end
   end
endmodule : tcdma_ctrl

// ===== shared/tcdma_pkg.sv
// Constants for the two-channel transfer controller channel block.
// Assumes a 32-bit APB slave, one register per aligned word.
// Notes on behaviour
// - Run bit loads only when write enable set
// - Write-enable bit never stored, reads zero
// - Count-stop bit ends channel at zero count
// - Zero count always clears run bit
// - Count decrements after every transfer
// - Unsynchronized mode stops at zero count
// - Sync field: none, source, destination, unused
// - Source pointer steps by one or two
// - Destination pointer steps by one or two
// - Both step bits set keeps pointer
// - Space bit selects memory or I/O
// - Priority bit; equal priority alternates channels
// - Timer request enable gates timer requests
// - Interrupt enable requests interrupt at termination
// - Pointer is 20 bits in two halves
// - Pointers accept any value, odd included
// - Control writes affect transfer in progress
// - Back-to-back transfers in source/unsync modes
// - Destination sync fetches only after request
// - Destination sync leaves two-clock gap
// - Transfer is fetch cycle then store cycle
// - Runs only with run bit and, in synchronized modes, request
// - Reset stops channels and aborts transfers
// - Non-maskable interrupt blocks new transfer starts; cycles in progress finish
package tcdma_pkg;
   localparam logic [7:0] TCDMA_SRC_LO = 8'h00;
   localparam logic [7:0] TCDMA_SRC_HI = 8'h04;
   localparam logic [7:0] TCDMA_DST_LO = 8'h08;
   localparam logic [7:0] TCDMA_DST_HI = 8'h0C;
   localparam logic [7:0] TCDMA_CNT    = 8'h10;
   localparam logic [7:0] TCDMA_CTRL   = 8'h14;
   localparam logic [7:0] TCDMA_STAT   = 8'h18;
   localparam logic [7:0] TCDMA_CH_STRIDE = 8'h20;
   localparam int B_WORD  = 0;
   localparam int B_RUN   = 1;
   localparam int B_RUNWE = 2;
   localparam int B_TIMER = 4;
   localparam int B_PRIO  = 5;
   localparam int B_SYNL  = 6;
   localparam int B_INTEN = 8;
   localparam int B_TCSTP = 9;
   localparam int B_SINC  = 10;
   localparam int B_SDEC  = 11;
   localparam int B_SMEM  = 12;
   localparam int B_DINC  = 13;
   localparam int B_DDEC  = 14;
   localparam int B_DMEM  = 15;
   localparam logic [15:0] TCDMA_CTRL_RST = 16'h0000;
   localparam int TCDMA_GAP_CYC = 2;
   typedef enum logic [1:0] {
      SYN_NONE = 2'b00,
      SYN_SRC  = 2'b01,
      SYN_DST  = 2'b10,
      SYN_UNUS = 2'b11
   } tcdma_syn_e;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_STORE = 2'b10,
      ST_GAP   = 2'b11
   } tcdma_st_e;
endpackage : tcdma_pkg

// ===== tb/tcdma_bus_model.sv
// Bus unit stand-in: ends each fetch or store after a delay.
// Assumes no new cycle is requested before the last one ends.
`timescale 1ns/1ns
module tcdma_bus_model (
   input  wire logic clk,     // clock
   input  wire logic rst,     // reset
   input  wire logic cyc_req, // cycle start
   input  wire logic slow,    // wait states
   output logic      cyc_done // end pulse
);
   logic [2:0] wait_r;
   always_ff @(posedge clk) begin
      cyc_done <= 1'b0;
      if (rst) begin
         wait_r <= 3'h0;
      end else if (cyc_req) begin
         wait_r <= slow ? 3'h4 : 3'h1;
      end else if (wait_r != 3'h0) begin
         wait_r <= wait_r - 3'h1;
         cyc_done <= wait_r == 3'h1;
      end
   end
endmodule : tcdma_bus_model

// ===== tb/tcdma_chk.sv
// Port checker for the transfer controller.
// Assumes bind to tcdma_ctrl, one clock, synchronous reset.
`timescale 1ns/1ns
module tcdma_chk
   import tcdma_pkg::*;
(
   input wire logic        clk,      // clock
   input wire logic        rst,      // reset
   input wire logic        psel,     // select
   input wire logic        penable,  // enable
   input wire logic        pwrite,   // write
   input wire logic [7:0]  paddr,    // address
   input wire logic [31:0] prdata,   // read data
   input wire logic        pready,   // ready
   input wire logic        nmi_req,  // halt
   input wire logic        cyc_done, // cycle end
   input wire logic        cyc_req,  // cycle start
   input wire logic        cyc_store,// store
   input wire logic [1:0]  irq       // interrupts
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("late ready");
   property p_rpulse; pready |=> !pready; endproperty
   a_rpulse: assert property (p_rpulse) else $error("long ready");
   property p_rdz;
      pready && !pwrite && paddr[4:0] == 5'h14 |-> prdata[3:2] == 2'b00;
   endproperty
   a_rdz: assert property (p_rdz) else $error("enable bit read");
   property p_irq; |irq |-> $past(cyc_done && cyc_store); endproperty
   a_irq: assert property (p_irq) else $error("stray irq");
   property p_fs; cyc_done && !cyc_store |=> cyc_req && cyc_store; endproperty
   a_fs: assert property (p_fs) else $error("no store");
   property p_req; cyc_req |=> !cyc_req; endproperty
   a_req: assert property (p_req) else $error("long cycle req");
   property p_nmi;
      nmi_req && $past(nmi_req) |-> !(cyc_req && !cyc_store);
   endproperty
   a_nmi: assert property (p_nmi) else $error("fetch in halt");
   property p_rst; $fell(rst) |-> !cyc_req && irq == 2'b00; endproperty
   a_rst: assert property (p_rst) else $error("busy at reset");
endmodule : tcdma_chk
bind tcdma_ctrl tcdma_chk u_chk (.clk, .rst, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .nmi_req, .cyc_done, .cyc_req, .cyc_store,
   .irq);

// ===== tb/two_channel_dma_channel_control_tb.sv
// Bench: APB register tasks, queued checks of every bus cycle.
// Assumes the bus model answers each cycle of the controller.
`timescale 1ns/1ns
module two_channel_dma_channel_control_tb;
   import tcdma_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, er, slow;
   logic timer_req, nmi_req, cyc_done, cyc_req, cyc_store, cyc_mem;
   logic cyc_word, cyc_chan;
   logic [1:0] xfer_req, irq;
   logic [7:0] paddr;
   logic [19:0] cyc_addr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] exp_q[$];
   int n_errors, compares, n_irq0, n_irq1, gap_n, exp_gap;
   tcdma_ctrl u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .xfer_req, .timer_req,
      .nmi_req, .cyc_done, .cyc_req, .cyc_store, .cyc_addr, .cyc_mem,
      .cyc_word, .cyc_chan, .irq);
   tcdma_bus_model u_bus (.clk, .rst, .cyc_req, .slow, .cyc_done);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   always @(posedge clk) begin
      if (irq[0] === 1'b1) n_irq0++;
      if (irq[1] === 1'b1) n_irq1++;
      if (cyc_req === 1'b1) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0);
         else chk({cyc_chan, cyc_store, cyc_mem, cyc_word, cyc_addr},
                  32'(exp_q.pop_front()));
      end
      if (cyc_req === 1'b1 && cyc_store === 1'b0 && gap_n >= 0)
         chk(32'(gap_n), 32'(exp_gap));
      if (cyc_done === 1'b1 && cyc_store === 1'b1) gap_n = 0;
      else if (gap_n >= 0) gap_n++;
   end
   task automatic xfer(input logic ch, input logic [15:0] c,
                       input logic hold);
      logic [7:0] b;
      logic [19:0] s, d, st;
      logic [15:0] n;
      b = ch ? TCDMA_CH_STRIDE : 8'h00;
      s = 20'($urandom);
      d = 20'($urandom);
      n = 16'(1 + $urandom % 3);
      st = c[B_WORD] ? 20'h2 : 20'h1;
      gap_n = -1;
      exp_gap = c[B_SYNL+1:B_SYNL] == SYN_DST ? 1 + TCDMA_GAP_CYC : 1;
      slow <= 1'($urandom);
      apb(1'b1, b + TCDMA_SRC_LO, 32'(s[15:0]));
      apb(1'b1, b + TCDMA_SRC_HI, 32'(s[19:16]));
      apb(1'b1, b + TCDMA_DST_LO, 32'(d[15:0]));
      apb(1'b1, b + TCDMA_DST_HI, 32'(d[19:16]));
      apb(1'b1, b + TCDMA_CNT, 32'(n));
      repeat (n) begin
         exp_q.push_back({ch, 1'b0, c[B_SMEM], c[B_WORD], s});
         exp_q.push_back({ch, 1'b1, c[B_DMEM], c[B_WORD], d});
         if (c[B_SINC] != c[B_SDEC]) s = c[B_SINC] ? s + st : s - st;
         if (c[B_DINC] != c[B_DDEC]) d = c[B_DINC] ? d + st : d - st;
      end
      nmi_req <= hold;
      apb(1'b1, b + TCDMA_CTRL, 32'(c));
      repeat (20) @(posedge clk);
      if (hold) chk(32'(exp_q.size()), 32'(n) * 2);
      nmi_req <= 1'b0;
      repeat (100) begin
         apb(1'b0, b + TCDMA_CTRL, 32'h0);
         if (rd[B_RUN] === 1'b0) break;
      end
      chk(rd, 32'(c) & 32'hFFF1);
      chk(32'(exp_q.size()), 32'h0);
      apb(1'b0, b + TCDMA_CNT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, b + TCDMA_SRC_LO, 32'h0);
      chk(rd, 32'(s[15:0]));
   endtask : xfer
   initial begin
      {psel, penable, pwrite, timer_req, nmi_req, slow} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      xfer_req = 2'b00;
      rst = 1'b1;
      rd = 32'($urandom(32'h3C0B));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, TCDMA_CTRL, 32'h0);
      chk(rd, 32'(TCDMA_CTRL_RST));
      nmi_req <= 1'b1;
      apb(1'b1, TCDMA_CTRL, 32'h2);
      apb(1'b0, TCDMA_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, TCDMA_CTRL, 32'h6);
      apb(1'b1, TCDMA_CTRL, 32'h2);
      apb(1'b0, TCDMA_CTRL, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, TCDMA_CTRL, 32'h4);
      apb(1'b0, TCDMA_CTRL, 32'h0);
      chk(rd, 32'h0);
      nmi_req <= 1'b0;
      apb(1'b0, 8'h1C, 32'h0);
      chk(32'(er), 32'h1);
      xfer(1'b0, 16'h5506, 1'b1);
      xfer_req <= 2'b10;
      xfer(1'b1, 16'hAE87, 1'b0);
      xfer_req <= 2'b00;
      timer_req <= 1'b1;
      xfer(1'b0, 16'h6657, 1'b0);
      apb(1'b1, TCDMA_CTRL, 32'h46);
      repeat (20) @(posedge clk);
      apb(1'b0, TCDMA_CTRL, 32'h0);
      chk(rd, 32'h42);
      apb(1'b1, TCDMA_CTRL, 32'hC6);
      repeat (20) @(posedge clk);
      apb(1'b0, TCDMA_CTRL, 32'h0);
      chk(rd, 32'hC2);
      apb(1'b1, TCDMA_CTRL, 32'h4);
      timer_req <= 1'b0;
      chk(32'(n_irq0), 32'h1);
      chk(32'(n_irq1), 32'h0);
      end_sim();
   end
   initial begin
      #300000;
      n_errors++;
      end_sim();
   end
endmodule : two_channel_dma_channel_control_tb
